// ### usf_status_flags.sv
// Status flag logic of the serial receiver and transmitter with an APB register port.
//
// Contract
// - Set parity fault flag when computed parity mismatches received parity bit.
// - Clear parity fault flag on receive buffer read after status read.
// - Set overrun flag when a frame completes while receive buffer is unread.
// - On overrun drop the new byte, keep receive buffer contents.
// - Clear overrun flag on receive buffer read after status read.
// - Set receive full flag whenever a completed byte loads the buffer.
// - Clear receive full flag on receive buffer read after status read.
// - Overrun raised between status read and buffer read survives that read.
// - Set transmit empty flag when the byte moves into the shifter.
// - Clear transmit empty flag on transmit buffer write after status read.
// - Set transmit done flag when a frame ends with no byte waiting.
// - Clear transmit done flag when a new transmission starts.
// - Pulse receive interrupt together with setting the receive full flag.
// - Pulse transmit interrupt when transmission starts and empty flag sets.
// - A transmit write without prior status read is ignored entirely.
//
// Register access over APB and the register addresses were chosen for this implementation.
module usf_status_flags
    import usf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rx_frame_done,
    input  wire logic [7:0]        rx_data,
    input  wire logic              rx_parity_bad,
    output logic                   tx_pending,
    output logic      [7:0]        tx_holding_data,
    input  wire logic              tx_load,
    input  wire logic              tx_frame_done,
    output logic                   rx_interrupt,
    output logic                   tx_interrupt
);
    // ----------------------------------------------------------------
    // Flags, buffers and arm bits
    // ----------------------------------------------------------------
    logic       parity_fault_flag;
    logic       overrun_flag;
    logic       rx_full_flag;
    logic       tx_done_flag;
    logic       tx_buffer_empty_flag;
    logic [7:0] rx_holding_buffer;
    logic [7:0] tx_holding_buffer;
    logic       arm_parity;
    logic       arm_overrun;
    logic       arm_rx_full;
    logic       arm_tx_empty;
    logic [7:0] serial_status_reg;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function automatic logic usf_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
        usf_hit = (addr == ADDR_W'(offset));
    endfunction

    logic setup_phase;
    logic access_phase;
    logic hit_status;
    logic hit_rxdata;
    logic hit_txdata;
    logic status_read;
    logic rx_read;
    logic tx_write;
    logic tx_accept;
    logic rx_store;
    logic tx_start;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign hit_status   = usf_hit(paddr, USF_STATUS_OFFSET);
    assign hit_rxdata   = usf_hit(paddr, USF_RXDATA_OFFSET);
    assign hit_txdata   = usf_hit(paddr, USF_TXDATA_OFFSET);
    assign status_read  = access_phase && !pwrite && hit_status;
    assign rx_read      = access_phase && !pwrite && hit_rxdata;
    assign tx_write     = access_phase && pwrite && hit_txdata;
    // Only a write whose empty flag was seen by a status read is taken.
    assign tx_accept    = tx_write && arm_tx_empty;
    assign rx_store     = rx_frame_done && !rx_full_flag;
    assign tx_start     = tx_load && tx_pending;

    assign pready = 1'b1;
    // Only status and receive data read, only transmit data writes; all else errors.
    assign pslverr = access_phase &&
                     !((!pwrite && (hit_status || hit_rxdata)) || (pwrite && hit_txdata));

    always_comb begin
        serial_status_reg = 8'h00;
        serial_status_reg[USF_PARITY_BIT]  = parity_fault_flag;
        serial_status_reg[USF_OVERRUN_BIT] = overrun_flag;
        serial_status_reg[USF_RXFULL_BIT]  = rx_full_flag;
        serial_status_reg[USF_TXDONE_BIT]  = tx_done_flag;
        serial_status_reg[USF_TXEMPTY_BIT] = tx_buffer_empty_flag;
    end

    // Read data is captured in the setup cycle so that the arm bits match
    // exactly the word software sees, even if a flag moves in the access cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= USF_RDATA_RESET;
        end else if (setup_phase && !pwrite) begin
            if (hit_status) begin
                prdata <= {24'h000000, serial_status_reg};
            end else if (hit_rxdata) begin
                prdata <= {24'h000000, rx_holding_buffer};
            end else begin
                prdata <= USF_RDATA_RESET;
            end
        end
    end

    // ----------------------------------------------------------------
    // Arm bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arm_parity   <= 1'b0;
            arm_overrun  <= 1'b0;
            arm_rx_full  <= 1'b0;
            arm_tx_empty <= 1'b0;
        end else begin
            if (status_read) begin
                arm_parity  <= prdata[USF_PARITY_BIT];
                arm_overrun <= prdata[USF_OVERRUN_BIT];
                arm_rx_full <= prdata[USF_RXFULL_BIT];
            end else if (rx_read) begin
                arm_parity  <= 1'b0;
                arm_overrun <= 1'b0;
                arm_rx_full <= 1'b0;
            end
            if (status_read) begin
                arm_tx_empty <= prdata[USF_TXEMPTY_BIT];
            end else if (tx_write) begin
                arm_tx_empty <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive side
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_holding_buffer <= USF_BUFFER_RESET;
        end else if (rx_store) begin
            rx_holding_buffer <= rx_data;
        end
    end

    // In every flag below a new event wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_fault_flag <= USF_PARITY_RESET;
        end else if (rx_frame_done && rx_parity_bad) begin
            parity_fault_flag <= 1'b1;
        end else if (rx_read && arm_parity) begin
            parity_fault_flag <= 1'b0;
        end
    end

    // An overrun that arrives after the status read is not armed and so stays.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overrun_flag <= USF_OVERRUN_RESET;
        end else if (rx_frame_done && rx_full_flag) begin
            overrun_flag <= 1'b1;
        end else if (rx_read && arm_overrun) begin
            overrun_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_full_flag <= USF_RXFULL_RESET;
        end else if (rx_store) begin
            rx_full_flag <= 1'b1;
        end else if (rx_read && arm_rx_full) begin
            rx_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_interrupt <= 1'b0;
        end else begin
            rx_interrupt <= rx_store;
        end
    end

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_holding_buffer <= USF_BUFFER_RESET;
        end else if (tx_accept) begin
            tx_holding_buffer <= pwdata[7:0];
        end
    end

    // Write and shifter load cannot meet: a write needs the flag set, a load needs it clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buffer_empty_flag <= USF_TXEMPTY_RESET;
        end else if (tx_start) begin
            tx_buffer_empty_flag <= 1'b1;
        end else if (tx_accept) begin
            tx_buffer_empty_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_done_flag <= USF_TXDONE_RESET;
        end else if (tx_frame_done && tx_buffer_empty_flag) begin
            tx_done_flag <= 1'b1;
        end else if (tx_start) begin
            tx_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_interrupt <= 1'b0;
        end else begin
            tx_interrupt <= tx_start;
        end
    end

    assign tx_pending      = !tx_buffer_empty_flag;
    assign tx_holding_data = tx_holding_buffer;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking usf_cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_parity_set: assert property (
        rx_frame_done && rx_parity_bad |=> parity_fault_flag &&
        serial_status_reg[USF_PARITY_BIT])
        else $error("Parity fault flag not set after bad parity.");

    a_parity_clear: assert property (
        rx_read && arm_parity && !rx_frame_done |=> !parity_fault_flag)
        else $error("Parity fault flag not cleared by armed buffer read.");

    a_overrun_set: assert property (
        rx_frame_done && rx_full_flag |=> overrun_flag ##1 (overrun_flag || $past(rx_read)))
        else $error("Overrun flag not set on frame into full buffer.");

    a_overrun_drop: assert property (
        rx_frame_done && rx_full_flag |=> $stable(rx_holding_buffer) && !rx_interrupt)
        else $error("Receive buffer changed on overrun.");

    a_overrun_clear: assert property (
        rx_read && arm_overrun && !rx_frame_done |=> !overrun_flag)
        else $error("Overrun flag not cleared by armed buffer read.");

    a_rxfull_set: assert property (
        rx_store |=> rx_full_flag && rx_holding_buffer == $past(rx_data))
        else $error("Receive full flag or buffer wrong after store.");

    a_rxfull_clear: assert property (
        rx_read && arm_rx_full && !rx_frame_done |=> !rx_full_flag)
        else $error("Receive full flag not cleared by armed buffer read.");

    a_overrun_survive: assert property (
        rx_read && overrun_flag && !arm_overrun |=> overrun_flag)
        else $error("Unarmed overrun flag lost on buffer read.");

    a_txempty_set: assert property (
        tx_start |=> tx_buffer_empty_flag && !tx_pending)
        else $error("Transmit empty flag not set on shifter load.");

    a_txempty_clear: assert property (
        tx_accept |=> !tx_buffer_empty_flag && tx_holding_data == $past(pwdata[7:0]))
        else $error("Transmit empty flag not cleared by armed write.");

    a_txdone_set: assert property (
        tx_frame_done && tx_buffer_empty_flag |=> tx_done_flag)
        else $error("Transmit done flag not set at idle frame end.");

    a_txdone_clear: assert property (
        tx_start && !tx_frame_done |=> !tx_done_flag)
        else $error("Transmit done flag not cleared on start.");

    a_rx_irq: assert property (
        rx_interrupt |-> rx_full_flag && $rose(rx_full_flag))
        else $error("Receive interrupt not aligned with receive full flag.");

    a_tx_irq: assert property (
        tx_interrupt |-> tx_buffer_empty_flag && $past(tx_pending))
        else $error("Transmit interrupt not aligned with empty flag set.");

    a_tx_unarmed: assert property (
        tx_write && !arm_tx_empty |=> $stable(tx_holding_buffer) && tx_buffer_empty_flag ==
        $past(tx_buffer_empty_flag))
        else $error("Unarmed transmit write took effect.");

    a_arm_capture: assert property (
        status_read |=> arm_overrun == $past(prdata[USF_OVERRUN_BIT]) &&
        arm_rx_full == $past(prdata[USF_RXFULL_BIT]))
        else $error("Arm bits do not match the status word read.");
endmodule

// ### usf_pkg.sv
// Package of offsets, field positions and reset values for the serial status flag block.
package usf_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] USF_STATUS_OFFSET  = 8'h00;
    localparam logic [7:0] USF_RXDATA_OFFSET  = 8'h04;
    localparam logic [7:0] USF_TXDATA_OFFSET  = 8'h08;

    // ----------------------------------------------------------------
    // Status field positions
    // ----------------------------------------------------------------
    localparam int USF_PARITY_BIT  = 7;
    localparam int USF_FRAMING_BIT = 6;
    localparam int USF_OVERRUN_BIT = 5;
    localparam int USF_RXFULL_BIT  = 4;
    localparam int USF_TXDONE_BIT  = 3;
    localparam int USF_TXEMPTY_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic       USF_PARITY_RESET  = 1'b0;
    localparam logic       USF_OVERRUN_RESET = 1'b0;
    localparam logic       USF_RXFULL_RESET  = 1'b0;
    localparam logic       USF_TXDONE_RESET  = 1'b1;
    localparam logic       USF_TXEMPTY_RESET = 1'b1;
    localparam logic [7:0] USF_BUFFER_RESET  = 8'h00;
    localparam logic [31:0] USF_RDATA_RESET  = 32'h0000_0000;
endpackage

// ### usf_far_model.sv
// Behavioural model of the far serial device facing the status flag block.
module usf_far_model #(
    parameter int LOAD_DLY  = 8,
    parameter int FRAME_LEN = 20
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       tx_pending,
    input  wire logic [7:0] tx_holding_data,
    output logic            rx_frame_done,
    output logic      [7:0] rx_data,
    output logic            rx_parity_bad,
    output logic            tx_load,
    output logic            tx_frame_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] last_tx;

    // ----------------------------------------------------------------
    // Receive side
    // ----------------------------------------------------------------
    // The data lines show the inverse byte outside the frame pulse, so a design that
    // samples them late cannot pass by luck.
    task automatic send(input logic [7:0] d, input logic bad);
        @(posedge clk);
        rx_frame_done <= 1'b1;
        rx_data       <= d;
        rx_parity_bad <= bad;
        @(posedge clk);
        rx_frame_done <= 1'b0;
        rx_data       <= ~d;
        rx_parity_bad <= ~bad;
    endtask

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    initial begin
        rx_frame_done = 1'b0;
        rx_data       = 8'h00;
        rx_parity_bad = 1'b0;
        tx_load       = 1'b0;
        tx_frame_done = 1'b0;
        last_tx       = 8'h00;
        forever begin
            @(posedge clk);
            if (reset_n === 1'b1 && tx_pending === 1'b1) begin
                repeat (LOAD_DLY) @(posedge clk);
                tx_load <= 1'b1;
                last_tx <= tx_holding_data;
                @(posedge clk);
                tx_load <= 1'b0;
                repeat (FRAME_LEN) @(posedge clk);
                tx_frame_done <= 1'b1;
                @(posedge clk);
                tx_frame_done <= 1'b0;
            end
        end
    end
endmodule

// ### tb_usf_status_flags.sv
// Self-checking testbench of the serial status flag block.
module tb_usf_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import usf_pkg::*;

    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, tx_holding_data, rx_data;
    logic [31:0] pwdata, prdata, rd;
    logic        err, tx_pending, tx_load, tx_frame_done, rx_frame_done, rx_parity_bad;
    logic        rx_interrupt, tx_interrupt;
    int          miscompares, samples_checked, rx_irqs, tx_irqs;

    usf_status_flags i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_frame_done(rx_frame_done), .rx_data(rx_data),
        .rx_parity_bad(rx_parity_bad), .tx_pending(tx_pending),
        .tx_holding_data(tx_holding_data), .tx_load(tx_load), .tx_frame_done(tx_frame_done),
        .rx_interrupt(rx_interrupt), .tx_interrupt(tx_interrupt));

    usf_far_model i_far (.clk(clk), .reset_n(reset_n), .tx_pending(tx_pending),
        .tx_holding_data(tx_holding_data), .rx_frame_done(rx_frame_done), .rx_data(rx_data),
        .rx_parity_bad(rx_parity_bad), .tx_load(tx_load), .tx_frame_done(tx_frame_done));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Each cycle an interrupt stands high counts once, so a stretched pulse shows up.
    always @(posedge clk) begin
        if (rx_interrupt === 1'b1) rx_irqs++;
        if (tx_interrupt === 1'b1) tx_irqs++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 16) begin
                miscompares++;
                end_sim();
            end
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wait_hi(input bit pick_irq);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                miscompares++;
                end_sim();
            end
        end while ((pick_irq ? tx_interrupt : tx_frame_done) !== 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_rx_full;
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        i_far.send(8'hA5, 1'b0);
        rd_chk(USF_RXDATA_OFFSET, 32'h0000_00A5);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_001C);
        check(rx_irqs, 32'h0000_0001);
        rd_chk(USF_RXDATA_OFFSET, 32'h0000_00A5);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        $display("test rx_full done");
    endtask

    task automatic t_overrun_parity;
        i_far.send(8'h11, 1'b0);
        i_far.send(8'h22, 1'b1);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_00BC);
        rd_chk(USF_RXDATA_OFFSET, 32'h0000_0011);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        $display("test overrun_parity done");
    endtask

    task automatic t_late_overrun;
        i_far.send(8'h33, 1'b0);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_001C);
        i_far.send(8'h44, 1'b0);
        rd_chk(USF_RXDATA_OFFSET, 32'h0000_0033);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_002C);
        rd_chk(USF_RXDATA_OFFSET, 32'h0000_0033);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        check(rx_irqs, 32'h0000_0003);
        $display("test late_overrun done");
    endtask

    task automatic t_transmit;
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        apb(1'b1, USF_TXDATA_OFFSET, 32'h0000_005A);
        @(posedge clk);
        check(tx_pending, 32'h0000_0001);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_0008);
        wait_hi(1'b1);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_0004);
        check(i_far.last_tx, 32'h0000_005A);
        check(tx_irqs, 32'h0000_0001);
        wait_hi(1'b0);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        $display("test transmit done");
    endtask

    // The last status read left the transmit arm set, so the first write is taken and
    // spends it; every later write without a fresh status read must be ignored.
    task automatic t_refused;
        apb(1'b1, USF_TXDATA_OFFSET, 32'h0000_0066);
        apb(1'b1, USF_TXDATA_OFFSET, 32'h0000_0077);
        @(posedge clk);
        check(tx_holding_data, 32'h0000_0066);
        wait_hi(1'b1);
        check(i_far.last_tx, 32'h0000_0066);
        wait_hi(1'b0);
        apb(1'b1, USF_TXDATA_OFFSET, 32'h0000_0077);
        repeat (12) @(posedge clk);
        check(tx_pending, 32'h0000_0000);
        check(tx_irqs, 32'h0000_0002);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        check(err, 32'h0000_0001);
        apb(1'b1, USF_STATUS_OFFSET, 32'h0000_0000);
        check(err, 32'h0000_0001);
        rd_chk(USF_STATUS_OFFSET, 32'h0000_000C);
        check(err, 32'h0000_0000);
        $display("test refused done");
    endtask

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        miscompares = 0;
        samples_checked = 0;
        rx_irqs = 0;
        tx_irqs = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_rx_full();
        t_overrun_parity();
        t_late_overrun();
        t_transmit();
        t_refused();
        end_sim();
    end
endmodule
